/* File: shared/masp_pkg.sv */
`default_nettype none
package masp_pkg;
	// Reset and timing
	localparam int unsigned INIT_CYCLES_DEF = 8192;
	localparam logic [1:0] MDIV = 2'h2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Register byte offsets
	localparam logic [7:0] ADR_SIN_CTRL = 8'h00;
	localparam logic [7:0] ADR_OUT0_CTRL = 8'h04;
	localparam logic [7:0] ADR_OUT1_CTRL = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_CAP_L = 8'h10;
	localparam logic [7:0] ADR_CAP_R = 8'h14;
	localparam logic [1:0] BANK_IN = 2'h1;
	localparam logic [1:0] BANK_OUT = 2'h2;
	// Field layout
	localparam logic [7:0] SIN_MASK = 8'h37;
	localparam logic [7:0] OUT0_MASK = 8'h77;
	localparam logic [7:0] OUT1_MASK = 8'hf7;
	localparam int WL_LSB = 4;
	localparam int MST_BIT = 6;
	localparam int CAP_BIT = 7;
	typedef enum logic [2:0] {
		FMT_I2S = 3'h0,
		FMT_LJ = 3'h1,
		FMT_RJ = 3'h2,
		FMT_TDM8 = 3'h3,
		FMT_TDM16 = 3'h4
	} masp_fmt_t;
	typedef enum logic [1:0] {ST_INIT = 2'h1, ST_RUN = 2'h2} masp_st_t;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} masp_ahb_in_t;
	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} masp_ahb_out_t;
	typedef struct packed {
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic fclk;
		logic [8:0] pos;
		logic tog;
		logic [3:0][23:0] shf;
		logic [15:0][23:0] hold;
	} masp_lnk_t;
	typedef struct packed {
		logic [2:0] bsy;
		logic [1:0] fsy;
		logic [1:0] div;
		logic bgen;
		logic fgen;
		logic fprev;
		logic [8:0] mcnt;
		logic [8:0] pos;
		logic [3:0] dout;
	} masp_grp_t;
	typedef struct packed {
		masp_st_t st;
		logic [15:0] icnt;
		logic [7:0] sin_ctrl;
		logic [1:0][7:0] octl;
		logic [1:0][27:0] cap;
		logic [15:0][27:0] osmp;
		logic [15:0][27:0] ismp;
		logic [2:0] tsy;
		logic [15:0] fcount;
		logic [7:0] a_addr;
		logic a_wr;
		logic a_ok;
		logic [31:0] rdata;
		masp_grp_t [1:0] grp;
	} masp_core_t;
	function automatic logic [4:0] wlen(input logic [1:0] c);
		case (c)
			2'h1: return 5'h14;
			2'h2: return 5'h10;
			default: return 5'h18;
		endcase
	endfunction
	function automatic logic is_tdm(input logic [2:0] f);
		return (f == FMT_TDM8) || (f == FMT_TDM16);
	endfunction
	function automatic logic slvl(input logic [2:0] f);
		return (f == FMT_LJ) || (f == FMT_RJ) || is_tdm(f);
	endfunction
	function automatic logic [5:0] offs(input logic [2:0] f, input logic [4:0] w);
		if (f == FMT_RJ)
			return 6'(6'h20 - {1'b0, w});
		return (slvl(f)) ? 6'h0 : 6'h1;
	endfunction
	function automatic logic [23:0] clip(input logic [27:0] v);
		if ((&v[27:23]) || !(|v[27:23]))
			return v[23:0];
		return v[27] ? 24'h800000 : 24'h7fffff;
	endfunction
endpackage
`default_nettype wire

/* File: design/masp_top.sv */
// Functional notes
// - Input format comes from bits 2:0 of the serial input control register.
// - Dual-wire TDM8 input: channels 0-7 on line 3, 8-15 on line 2.
// - Single-wire TDM16 input: channels 0-15 all on line 2.
// - Input port is always slave; source drives frame and bit clocks.
// - Stereo output: sixteen channels, two per line on eight lines.
// - Output lines 0-3 and 4-7 form groups with separate mode settings.
// - TDM8 output: 0-7 on line 0, 8-15 on line 4; TDM16 line 0 only.
// - Lines 0-3 timed by clock pair 0, lines 4-7 by pair 1.
// - Output clock pairs are inputs in slave mode; slave after reset.
// - Output line 7 may carry the data capture stream.
// - After reset release, memories and control registers are cleared.
// - Initialization ends 8192 clock cycles after reset release.
// - Core samples are 28-bit two's complement in 5.23 format.
// - Input words up to 24 bits are sign-extended to 28 bits.
// - Outputs saturate to 24 bits, range -1.0 to just below +1.0.
// - Framing modes: I2S, left-justified, right-justified, TDM.
// - Words are 16, 20 or 24 bits, MSB first, two's complement.
`timescale 1ns/1ps
`default_nettype none
module masp_top
	import masp_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = masp_pkg::INIT_CYCLES_DEF
)
(
	// Core clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register bus
	input wire masp_pkg::masp_ahb_in_t AHB_IN,
	output masp_pkg::masp_ahb_out_t AHB_OUT,
	// Serial input port
	input wire logic IN_BIT_CLOCK,
	input wire logic IN_FRAME_CLOCK,
	input wire logic [3:0] SERIAL_IN_LINE,
	// Serial output port
	output logic [7:0] SERIAL_OUT_LINE,
	input wire logic [1:0] OUT_GROUP_BIT_CLOCK_I,
	output logic [1:0] OUT_GROUP_BIT_CLOCK_O,
	output logic [1:0] OUT_GROUP_BIT_CLOCK_OE,
	input wire logic [1:0] OUT_GROUP_FRAME_CLOCK_I,
	output logic [1:0] OUT_GROUP_FRAME_CLOCK_O,
	output logic [1:0] OUT_GROUP_FRAME_CLOCK_OE
);
	import masp_pkg::*;

	masp_lnk_t ln_q, ln_d;
	masp_core_t core_q, core_d;
	masp_grp_t gd;
	logic [2:0] lfmt, fo;
	logic [4:0] lw, wo;
	logic lstart, run, ms, tick, lr, fst, newfr, aph;
	logic [5:0] lk, ok;
	logic [4:0] isel, osel;
	logic [27:0] smp;
	logic [23:0] wd;
	logic [7:0] ctl;

	// Input channel decode: {valid, channel}
	function automatic logic [4:0] in_ch(input logic [2:0] f, input logic [1:0] l,
		input logic [3:0] s);
		case (f)
			FMT_TDM8: return (l == 2'h3) ? {!s[3], 1'b0, s[2:0]} :
				(l == 2'h2) ? {!s[3], 1'b1, s[2:0]} : 5'h0;
			FMT_TDM16: return (l == 2'h2) ? {1'b1, s} : 5'h0;
			default: return {s[3:1] == 3'h0, 1'b0, l, s[0]};
		endcase
	endfunction

	// Output channel decode: {valid, channel}
	function automatic logic [4:0] out_ch(input logic [2:0] f, input logic [2:0] l,
		input logic [3:0] s);
		case (f)
			FMT_TDM8: return (l == 3'h0) ? {!s[3], 1'b0, s[2:0]} :
				(l == 3'h4) ? {!s[3], 1'b1, s[2:0]} : 5'h0;
			FMT_TDM16: return (l == 3'h0) ? {1'b1, s} : 5'h0;
			default: return {s[3:1] == 3'h0, l, s[0]};
		endcase
	endfunction

	function automatic logic lrgen(input logic [2:0] f, input logic [8:0] m);
		if (is_tdm(f))
			return m[8:5] == 4'h0;
		return slvl(f) ? !m[5] : m[5];
	endfunction

	function automatic logic [8:0] flast(input logic [2:0] f);
		case (f)
			FMT_TDM8: return 9'h0ff;
			FMT_TDM16: return 9'h1ff;
			default: return 9'h03f;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Input port, clocked by the source's bit clock
	always_comb
	begin
		ln_d = ln_q;
		ln_d.cfg1 = core_q.sin_ctrl;
		ln_d.cfg2 = ln_q.cfg1;
		lfmt = ln_q.cfg2[2:0];
		lw = wlen(ln_q.cfg2[WL_LSB+:2]);
		lstart = (IN_FRAME_CLOCK != ln_q.fclk) && (IN_FRAME_CLOCK == slvl(lfmt));
		ln_d.fclk = IN_FRAME_CLOCK;
		ln_d.pos = lstart ? 9'h0 : ((&ln_q.pos) ? ln_q.pos : ln_q.pos + 9'h1);
		if (lstart)
			ln_d.tog = !ln_q.tog;
		lk = 6'({1'b0, ln_d.pos[4:0]} - offs(lfmt, lw));
		isel = 5'h0;
		for (int l = 0; l < 4; l++)
		begin
			if (lk < {1'b0, lw})
				ln_d.shf[l] = {ln_q.shf[l][22:0], SERIAL_IN_LINE[l]};
			isel = in_ch(lfmt, 2'(l), ln_d.pos[8:5]);
			if (lk == 6'({1'b0, lw} - 6'h1) && isel[4])
				ln_d.hold[isel[3:0]] = 24'(ln_d.shf[l] << (5'h18 - lw));
		end
	end

	always_ff @(posedge IN_BIT_CLOCK or posedge RST)
	begin
		if (RST)
			ln_q <= '0;
		else
			ln_q <= ln_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Core side: bus slave, initialization, output groups
	always_comb
	begin
		core_d = core_q;
		run = core_q.st == ST_RUN;
		gd = '0;
		fo = 3'h0;
		wo = 5'h0;
		ms = 1'b0;
		tick = 1'b0;
		lr = 1'b0;
		fst = 1'b0;
		ok = 6'h0;
		osel = 5'h0;
		smp = 28'h0;
		wd = 24'h0;
		ctl = 8'h0;
		case (core_q.st)
			ST_INIT:
			begin
				core_d.icnt = core_q.icnt + 16'h1;
				core_d.osmp[core_q.icnt[3:0]] = 28'h0;
				core_d.ismp[core_q.icnt[3:0]] = 28'h0;
				if (core_q.icnt == 16'(INIT_CYCLES - 1))
					core_d.st = ST_RUN;
			end
			ST_RUN: core_d.icnt = core_q.icnt;
			default: core_d.st = ST_INIT;
		endcase
		// Frame hand-over from the input domain
		core_d.tsy = {core_q.tsy[1:0], ln_q.tog};
		newfr = core_q.tsy[2] != core_q.tsy[1];
		if (newfr && run)
		begin
			core_d.fcount = core_q.fcount + 16'h1;
			for (int i = 0; i < 16; i++)
				core_d.ismp[i] = {{4{ln_q.hold[i][23]}}, ln_q.hold[i]};
		end
		// Bus: write in data phase, read data captured in address phase
		aph = AHB_IN.hsel && AHB_IN.htrans[1] && AHB_IN.hready;
		if (core_q.a_wr && core_q.a_ok)
		begin
			case (core_q.a_addr)
				ADR_SIN_CTRL: core_d.sin_ctrl = AHB_IN.hwdata[7:0] & SIN_MASK;
				ADR_OUT0_CTRL: core_d.octl[0] = AHB_IN.hwdata[7:0] & OUT0_MASK;
				ADR_OUT1_CTRL: core_d.octl[1] = AHB_IN.hwdata[7:0] & OUT1_MASK;
				ADR_CAP_L: core_d.cap[0] = AHB_IN.hwdata[27:0];
				ADR_CAP_R: core_d.cap[1] = AHB_IN.hwdata[27:0];
				default:
				begin
					if (core_q.a_addr[7:6] == BANK_OUT)
						core_d.osmp[core_q.a_addr[5:2]] = AHB_IN.hwdata[27:0];
				end
			endcase
		end
		core_d.a_wr = aph && AHB_IN.hwrite;
		core_d.a_ok = (AHB_IN.haddr[31:8] == 24'h0) && (AHB_IN.haddr[1:0] == 2'h0);
		core_d.a_addr = AHB_IN.haddr[7:0];
		if (aph && !AHB_IN.hwrite)
		begin
			core_d.rdata = 32'h0;
			if (core_d.a_ok)
			begin
				case (AHB_IN.haddr[7:0])
					ADR_SIN_CTRL: core_d.rdata = {24'h0, core_q.sin_ctrl};
					ADR_OUT0_CTRL: core_d.rdata = {24'h0, core_q.octl[0]};
					ADR_OUT1_CTRL: core_d.rdata = {24'h0, core_q.octl[1]};
					ADR_STATUS: core_d.rdata = {core_q.fcount, 15'h0, run};
					ADR_CAP_L: core_d.rdata = {4'h0, core_q.cap[0]};
					ADR_CAP_R: core_d.rdata = {4'h0, core_q.cap[1]};
					default:
					begin
						if (AHB_IN.haddr[7:6] == BANK_IN)
							core_d.rdata = {4'h0, core_q.ismp[AHB_IN.haddr[5:2]]};
						else if (AHB_IN.haddr[7:6] == BANK_OUT)
							core_d.rdata = {4'h0, core_q.osmp[AHB_IN.haddr[5:2]]};
					end
				endcase
			end
		end
		// Output groups, each on its own clock pair
		for (int g = 0; g < 2; g++)
		begin
			ctl = core_q.octl[g];
			fo = ctl[2:0];
			wo = wlen(ctl[WL_LSB+:2]);
			ms = ctl[MST_BIT] && run;
			gd = core_q.grp[g];
			gd.bsy = {core_q.grp[g].bsy[1:0], OUT_GROUP_BIT_CLOCK_I[g]};
			gd.fsy = {core_q.grp[g].fsy[0], OUT_GROUP_FRAME_CLOCK_I[g]};
			tick = 1'b0;
			if (ms)
			begin
				gd.div = core_q.grp[g].div + 2'h1;
				if (core_q.grp[g].div == MDIV - 2'h1)
				begin
					gd.div = 2'h0;
					gd.bgen = !core_q.grp[g].bgen;
					tick = core_q.grp[g].bgen;
				end
			end
			else
			begin
				gd.div = 2'h0;
				gd.bgen = 1'b0;
				tick = core_q.grp[g].bsy[2] && !core_q.grp[g].bsy[1];
			end
			if (tick)
			begin
				lr = ms ? lrgen(fo, core_q.grp[g].mcnt) : core_q.grp[g].fsy[1];
				gd.mcnt = (core_q.grp[g].mcnt == flast(fo)) ? 9'h0 :
					core_q.grp[g].mcnt + 9'h1;
				gd.fgen = lr;
				fst = (lr != core_q.grp[g].fprev) && (lr == slvl(fo));
				gd.fprev = lr;
				gd.pos = fst ? 9'h0 : ((&core_q.grp[g].pos) ? core_q.grp[g].pos :
					core_q.grp[g].pos + 9'h1);
				ok = 6'({1'b0, gd.pos[4:0]} - offs(fo, wo));
				for (int l = 0; l < 4; l++)
				begin
					osel = out_ch(fo, 3'(4 * g + l), gd.pos[8:5]);
					smp = core_q.osmp[osel[3:0]];
					if (g == 1 && l == 3 && core_q.octl[1][CAP_BIT])
					begin
						osel[4] = gd.pos[8:6] == 3'h0;
						smp = core_q.cap[gd.pos[5]];
					end
					wd = clip(smp);
					gd.dout[l] = osel[4] && (ok < {1'b0, wo}) && wd[5'(5'h17 - ok[4:0])];
				end
			end
			if (!run)
				gd.dout = 4'h0;
			core_d.grp[g] = gd;
		end
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			core_q <= '0;
			core_q.st <= ST_INIT;
			core_q.sin_ctrl <= CTRL_RST;
			core_q.octl <= {CTRL_RST, CTRL_RST};
		end
		else
			core_q <= core_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins and bus answer
	assign AHB_OUT.hreadyout = 1'b1;
	assign AHB_OUT.hresp = 1'b0;
	assign AHB_OUT.hrdata = core_q.rdata;
	assign SERIAL_OUT_LINE = {core_q.grp[1].dout, core_q.grp[0].dout};
	always_comb
	begin
		for (int g = 0; g < 2; g++)
		begin
			OUT_GROUP_BIT_CLOCK_O[g] = core_q.grp[g].bgen;
			OUT_GROUP_FRAME_CLOCK_O[g] = core_q.grp[g].fgen;
			OUT_GROUP_BIT_CLOCK_OE[g] = core_q.octl[g][MST_BIT] && run;
			OUT_GROUP_FRAME_CLOCK_OE[g] = core_q.octl[g][MST_BIT] && run;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [15:0] hcnt_q;
	logic [23:0] clip0;
	logic ms1;
	assign clip0 = clip(core_q.osmp[0]);
	assign ms1 = core_q.octl[1][MST_BIT] && run;
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			hcnt_q <= 16'h0;
		else if (core_q.st == ST_INIT)
			hcnt_q <= hcnt_q + 16'h1;
	end

	chk_init_length: assert property (@(posedge CLK) disable iff (RST)
		$rose(core_q.st == ST_RUN) |-> hcnt_q == 16'(INIT_CYCLES))
		else $error("initialization length wrong");
	chk_mute_init: assert property (@(posedge CLK) disable iff (RST)
		core_q.st == ST_INIT |=> SERIAL_OUT_LINE == 8'h0 && core_q.osmp[0] == 28'h0)
		else $error("outputs active during initialization");
	chk_slave_boot: assert property (@(posedge CLK) disable iff (RST)
		core_q.st == ST_INIT |-> OUT_GROUP_BIT_CLOCK_OE == 2'h0
		&& OUT_GROUP_FRAME_CLOCK_OE == 2'h0)
		else $error("clock pair driven before initialization end");
	chk_fmt_field: assert property (@(posedge CLK) disable iff (RST)
		core_q.a_wr && core_q.a_ok && core_q.a_addr == ADR_SIN_CTRL
		|=> core_q.sin_ctrl[2:0] == $past(AHB_IN.hwdata[2:0]))
		else $error("input format field not written");
	chk_frame_count: assert property (@(posedge CLK) disable iff (RST)
		core_q.tsy[2] != core_q.tsy[1] && run
		|=> core_q.fcount == $past(core_q.fcount) + 16'h1)
		else $error("input frame not handed over");
	chk_sign_ext: assert property (@(posedge CLK) disable iff (RST)
		core_q.tsy[2] != core_q.tsy[1] && run
		|=> core_q.ismp[3][27:23] == 5'h0 || core_q.ismp[3][27:23] == 5'h1f)
		else $error("input sample not sign extended");
	chk_clip_sat: assert property (@(posedge CLK) disable iff (RST)
		!core_q.osmp[0][27] && core_q.osmp[0][26:23] != 4'h0 |-> clip0 == 24'h7fffff)
		else $error("positive overflow not saturated");
	chk_tdm_lines: assert property (@(posedge CLK) disable iff (RST)
		$past(core_q.octl[0][2:0]) == FMT_TDM16 && $changed(core_q.grp[0].mcnt)
		|-> SERIAL_OUT_LINE[3:1] == 3'h0)
		else $error("idle lines active in single-wire TDM");
	chk_master_bclk: assert property (@(posedge CLK) disable iff (RST)
		ms1 && $rose(OUT_GROUP_BIT_CLOCK_O[1]) ##1 ms1 |=> !OUT_GROUP_BIT_CLOCK_O[1])
		else $error("master bit clock period wrong");
	chk_frame_start: assert property (@(posedge IN_BIT_CLOCK) disable iff (RST)
		lstart |=> ln_q.pos == 9'h0)
		else $error("frame start not aligned");

	cov_run: cover property (@(posedge CLK) disable iff (RST) $rose(core_q.st == ST_RUN));
	cov_frame: cover property (@(posedge CLK) disable iff (RST)
		run && core_q.tsy[2] != core_q.tsy[1]);
	cov_master: cover property (@(posedge CLK) disable iff (RST)
		ms1 && $fell(OUT_GROUP_BIT_CLOCK_O[1]));
	cov_capture: cover property (@(posedge CLK) disable iff (RST)
		core_q.octl[1][CAP_BIT] && SERIAL_OUT_LINE[7]);
endmodule // masp_top
`default_nettype wire

/* File: verif/masp_src.sv */
`timescale 1ns/1ps
`default_nettype none
module masp_src
	import masp_pkg::*;
(
	// Reset watch
	input wire logic rst,
	// Link toward the input port
	output logic bclk,
	output logic fclk,
	output logic [3:0] sdata
);
	logic [23:0] w [16];
	////////////////////////////////
	function automatic int chan(input logic [2:0] f, input int l, input int s);
		if (f == FMT_TDM8)
			return (l == 3) ? s : (l == 2) ? s + 8 : -1;
		if (f == FMT_TDM16)
			return (l == 2) ? s : -1;
		return 2 * l + s;
	endfunction
	// Clock runs only inside frames; idle bits toggle so no stale level survives
	task automatic send(input logic [2:0] f, input int wl, input int fr);
		int nb;
		int k;
		int ch;
		nb = (f == FMT_TDM16) ? 512 : (f == FMT_TDM8) ? 256 : 64;
		repeat (fr)
			for (int b = 0; b < nb; b++)
			begin
				fclk = (b < nb / 2) ^ (f == FMT_I2S);
				k = b % 32 - ((f == FMT_RJ) ? 32 - wl : (f == FMT_I2S) ? 1 : 0);
				for (int l = 0; l < 4; l++)
				begin
					ch = chan(f, l, b / 32);
					sdata[l] = (ch >= 0 && k >= 0 && k < wl) ? w[ch][23 - k] : ~sdata[l];
				end
				#32 bclk = 1'b1;
				#32 bclk = 1'b0;
			end
		fclk = 1'b0;
		sdata = ~sdata;
	endtask
	// Link domain has no synchronous release: give it edges inside reset
	initial
	begin
		bclk = 1'b0;
		fclk = 1'b0;
		sdata = 4'h5;
		wait (rst === 1'b1);
		repeat (2)
		begin
			#32 bclk = 1'b1;
			#32 bclk = 1'b0;
		end
	end
endmodule // masp_src
`default_nettype wire

/* File: verif/masp_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module masp_tb_top;
	import masp_pkg::*;
	localparam int INIT = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	masp_ahb_in_t m;
	masp_ahb_in_t ahb_in;
	masp_ahb_out_t ahb_out;
	logic bck_in;
	logic fck_in;
	logic [3:0] sin;
	logic [7:0] sout;
	logic [1:0] bo, boe, fo, foe, bck, fck;
	logic [9:0] xc = 10'h0;
	logic [27:0] iexp [16] = '{default: 28'h0};
	logic [27:0] capv [2];
	int err_count = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h3f221afe;
	logic [31:0] rd;
	logic [27:0] osmp [16];
	logic [23:0] cap [8][16];
	logic [2:0] gf [2] = '{FMT_I2S, FMT_I2S};
	int gw [2] = '{24, 24};
	int nfr [2] = '{0, 0};
	logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h30, 8'h40};
	logic [7:0] msk [5] = '{SIN_MASK, OUT0_MASK, OUT1_MASK, 8'h00, 8'h00};
	logic [2:0] ifm [6] = '{FMT_LJ, FMT_LJ, FMT_RJ, FMT_TDM8, FMT_TDM16, FMT_I2S};
	logic [1:0] iwc [6] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h2};
	logic [2:0] of0 [5] = '{FMT_LJ, FMT_RJ, FMT_TDM8, FMT_TDM16, FMT_LJ};
	logic [1:0] oc0 [5] = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
	logic [2:0] of1 [5] = '{FMT_I2S, FMT_LJ, FMT_TDM8, FMT_I2S, FMT_I2S};
	logic [1:0] oc1 [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0};
	logic [27:0] cor [4] = '{28'h7ffffff, 28'h8000000, 28'h07fffff, 28'hf800000};
	always #12.5 clk = ~clk;
	// Far-side slave clocks: 16 CLK per bit, 64 bits per frame
	always @(posedge clk)
		xc <= xc + 10'h1;
	// Pin level: our driver when enabled, otherwise the far side's clocks
	assign bck = (boe & bo) | (~boe & {2{xc[3]}});
	assign fck = (foe & fo) | (~foe & {2{xc[9]}});
	always_comb
	begin
		ahb_in = m;
		ahb_in.hready = ahb_out.hreadyout;
	end
	masp_top #(.INIT_CYCLES(INIT)) dut (
		.CLK(clk), .RST(rst), .AHB_IN(ahb_in), .AHB_OUT(ahb_out),
		.IN_BIT_CLOCK(bck_in), .IN_FRAME_CLOCK(fck_in), .SERIAL_IN_LINE(sin),
		.SERIAL_OUT_LINE(sout), .OUT_GROUP_BIT_CLOCK_I(bck), .OUT_GROUP_BIT_CLOCK_O(bo),
		.OUT_GROUP_BIT_CLOCK_OE(boe), .OUT_GROUP_FRAME_CLOCK_I(fck),
		.OUT_GROUP_FRAME_CLOCK_O(fo), .OUT_GROUP_FRAME_CLOCK_OE(foe));
	masp_src src (.rst(rst), .bclk(bck_in), .fclk(fck_in), .sdata(sin));
	////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int wlb(input logic [1:0] c);
		return (c == 2'h1) ? 20 : (c == 2'h2) ? 16 : 24;
	endfunction
	function automatic logic [23:0] sat24(input logic [27:0] v);
		if (v[27:23] == 5'h00 || v[27:23] == 5'h1f)
			return v[23:0];
		return v[27] ? 24'h800000 : 24'h7fffff;
	endfunction
	function automatic int och(input logic [2:0] f, input int l, input int s);
		if (f == FMT_TDM8)
			return (l % 4 == 0 && s < 8) ? s + 2 * l : -1;
		if (f == FMT_TDM16)
			return (l == 0) ? s : -1;
		return (s < 2) ? 2 * l + s : -1;
	endfunction
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic hrdy();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ahb_out.hreadyout !== 1'b1 && n < 64);
		if (n >= 64)
		begin
			err_count++;
			close_out();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		m.hsel <= 1'b1;
		m.haddr <= {24'h0, a};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		hrdy();
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= d;
		hrdy();
		rd = ahb_out.hrdata;
	endtask
	////////////////////////////////
	// Output monitor: one per clock group, slot bits keyed to frame start
	for (genvar g = 0; g < 2; g++)
	begin : mon
		int pos = 9999;
		int k;
		logic fp = 1'b0;
		always @(posedge bck[g])
		begin
			if ((gf[g] == FMT_I2S) ? (fp && !fck[g]) : (!fp && fck[g]))
			begin
				pos = 0;
				nfr[g]++;
			end
			else
				pos++;
			fp = fck[g];
			k = pos % 32 - ((gf[g] == FMT_I2S) ? 1 : (gf[g] == FMT_RJ) ? 32 - gw[g] : 0);
			for (int l = 4 * g; l < 4 * g + 4; l++)
				if (k >= 0 && k < gw[g] && pos < 512)
					cap[l][pos / 32][23 - k] = sout[l];
		end
	end
	initial
	begin
		#2000000;
		err_count++;
		close_out();
	end
	////////////////////////////////
	initial
	begin
		logic [23:0] w;
		logic [23:0] mk;
		logic [27:0] e;
		int ch;
		m = '0;
		m.hsize = 3'h2;
		repeat (8) @(posedge clk);
		chk("reset drive", 32'h0, {20'h0, boe, foe, sout});
		rst <= 1'b0;
		bus(1'b0, ADR_STATUS, 32'h0);
		chk("init flag", 32'h0, rd & 32'h1);
		repeat (10) @(posedge clk);
		bus(1'b0, ADR_STATUS, 32'h0);
		chk("init flag", 32'h0, rd & 32'h1);
		chk("muted", 32'h0, {24'h0, sout});
		repeat (10) @(posedge clk);
		bus(1'b0, ADR_STATUS, 32'h0);
		chk("init flag", 32'h1, rd & 32'h1);
		$display("reset test done");
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, adr[i], 32'h0);
			chk("reg reset", 32'h0, rd);
			bus(1'b1, adr[i], 32'hffffffff);
			bus(1'b0, adr[i], 32'h0);
			chk("reg field", {24'h0, msk[i]}, rd);
			bus(1'b1, adr[i], 32'h0);
		end
		$display("register test done");
		// Three frames: the first may meet the config change, the second is kept
		for (int t = 0; t < 6; t++)
		begin
			bus(1'b1, ADR_SIN_CTRL, {24'h0, 2'h0, iwc[t], 1'b0, ifm[t]});
			for (int n = 0; n < 16; n++)
				src.w[n] = 24'(rnd());
			src.send(ifm[t], wlb(iwc[t]), 3);
			repeat (8) @(posedge clk);
			for (int n = 0; n < 16; n++)
			begin
				bus(1'b0, 8'h40 + 8'(4 * n), 32'h0);
				w = src.w[n] & ~(24'hffffff >> wlb(iwc[t]));
				// Stereo carries channels 0-7 only; the others keep their last word
				if (n < 8 || ifm[t] == FMT_TDM8 || ifm[t] == FMT_TDM16)
					iexp[n] = {{4{w[23]}}, w};
				chk("in sample", {4'h0, iexp[n]}, rd & 32'h0fffffff);
			end
			$display("input test %0d done", t);
		end
		for (int n = 0; n < 16; n++)
		begin
			e = 28'(rnd());
			osmp[n] = (n < 4) ? cor[n] : e[0] ? {{4{e[23]}}, e[23:0]} : e;
			bus(1'b1, 8'h80 + 8'(4 * n), {4'h0, osmp[n]});
			bus(1'b0, 8'h80 + 8'(4 * n), 32'h0);
			chk("out sample", {4'h0, osmp[n]}, rd & 32'h0fffffff);
		end
		for (int i = 0; i < 2; i++)
		begin
			e = 28'(rnd());
			capv[i] = i ? e : {{4{e[23]}}, e[23:0]};
			bus(1'b1, i ? ADR_CAP_R : ADR_CAP_L, {4'h0, capv[i]});
		end
		$display("output samples done");
		// Last round: both groups slave, line 7 carries the capture pair
		for (int r = 0; r < 5; r++)
		begin
			gf[0] = of0[r];
			gf[1] = of1[r];
			gw[0] = wlb(oc0[r]);
			gw[1] = wlb(oc1[r]);
			bus(1'b1, ADR_OUT0_CTRL, {24'h0, 1'b0, 1'(r < 4), oc0[r], 1'b0, of0[r]});
			bus(1'b1, ADR_OUT1_CTRL, {24'h0, 1'(r == 4), 1'(r < 4), oc1[r], 1'b0, of1[r]});
			nfr = '{0, 0};
			for (int n = 0; n < 40000 && (nfr[0] < 3 || nfr[1] < 3); n++)
				@(posedge clk);
			if (nfr[0] < 3 || nfr[1] < 3)
			begin
				err_count++;
				close_out();
			end
			chk("clock drive", (r < 4) ? 32'h3 : 32'h0, {30'h0, boe & foe});
			for (int l = 0; l < 8; l++)
				for (int s = 0; s < 16; s++)
				begin
					ch = och(gf[l / 4], l, s);
					mk = ~(24'hffffff >> gw[l / 4]);
					if (ch >= 0)
					begin
						e = (l == 7 && r == 4) ? capv[s % 2] : osmp[ch];
						chk("out word", 32'(sat24(e) & mk), 32'(cap[l][s] & mk));
					end
				end
			$display("output round %0d done", r);
		end
		close_out();
	end
endmodule // masp_tb_top
`default_nettype wire
